// [rtl/dac_ctrl_consts.svh]
// register offsets, field positions and reset values of the dac control block
// assumes byte addresses on an 8-bit wishbone address, one 32-bit word per register
`ifndef DAC_CTRL_CONSTS_SVH
`define DAC_CTRL_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CONFIG     8'h00
`define OFS_SYNC_SEL   8'h04
`define OFS_PIN0_SEL   8'h08
`define OFS_PIN1_SEL   8'h0c
`define OFS_SW_CLEAR   8'h10
`define OFS_AUTO_SRC   8'h14
`define OFS_AUTO_EN    8'h18
`define OFS_ALARM_CTRL 8'h1c
`define OFS_STATUS     8'h20
`define OFS_POWER      8'h24
// address bits [7:6] select the per-channel windows
`define WIN_DATA       2'h1
`define WIN_CLR_CODE   2'h2

// ****************************************
// field positions
// ****************************************
`define BIT_LOAD_TRIGGER 0
`define BIT_GLOBAL_ALARM 1
`define BIT_OVERHEAT_SRC 2
`define LSB_AUTO_EN      3
`define BIT_LATCH_DIS    0
`define LSB_EVENT_EN     8

// ****************************************
// reset values and limits
// ****************************************
`define RESET_CODE       12'h000
`define OVERHEAT_LIMIT_C 150

`endif

// [rtl/dac_ctrl_pkg.sv]
// shared types of the dac control block
// assumes a 32-bit wishbone data path and 8-bit byte addresses
package dac_ctrl_pkg;
  typedef logic [7:0]  addr_type;   // wishbone byte address
  typedef logic [31:0] word_type;   // wishbone data word
  typedef logic [3:0]  sel_type;    // wishbone byte lanes
endpackage

// [rtl/alarm_status.sv]
// alarm status bits, latched or following their conditions
// assumes conditions are synchronous levels and readClear is a one-cycle pulse
`timescale 1ns/1ps
module alarm_status #(
  parameter int ALARMS = 8                  // number of alarm events
) (
  input  wire logic              clk,          // device clock
  input  wire logic              reset,        // synchronous, active high
  input  wire logic [ALARMS-1:0] condition,    // live alarm conditions
  input  wire logic              latchDisable, // 1: bits follow conditions
  input  wire logic              readClear,    // status register read pulse
  output logic      [ALARMS-1:0] status        // alarm status bits
);
  logic [ALARMS-1:0] next_status;  // status after this edge

  // ****************************************
  // status update
  // ****************************************
  // a live condition always wins over the read clear, so nothing is lost
  assign next_status = latchDisable ? condition
                     : condition | (status & ~{ALARMS{readClear}});

  // status register
  always_ff @(posedge clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_latched_hold: assert property (!latchDisable && !readClear
    |=> (status & $past(status)) == $past(status))
    else $error("latched alarm bit dropped without a read");
  a_read_clears: assert property (!latchDisable && readClear
    |=> status == $past(condition))
    else $error("status read did not clear idle bits");
  a_unlatched_follow: assert property (latchDisable
    |=> status == $past(condition))
    else $error("unlatched alarm bit does not follow condition");
endmodule

// [rtl/dac_channel.sv]
// one double-buffered dac channel: data register, output latch, clear handling
// assumes loadPulse is one cycle long and clearNow is a synchronous level
`timescale 1ns/1ps
`include "dac_ctrl_consts.svh"
module dac_channel #(
  parameter int WIDTH = 12                   // code width
) (
  input  wire logic             clk,        // device clock
  input  wire logic             reset,      // synchronous, active high
  input  wire logic             dataWrite,  // host writes the data register
  input  wire logic [WIDTH-1:0] dataIn,     // code written
  input  wire logic             loadPulse,  // internal load pulse
  input  wire logic             syncSelect, // channel takes part in loads
  input  wire logic             clearNow,   // channel is in the clear state
  input  wire logic [WIDTH-1:0] clearCode,  // code forced while cleared
  output logic      [WIDTH-1:0] dataReg,    // pending data register
  output logic      [WIDTH-1:0] latchCode   // output-determining latch
);
  logic             dirty;      // data written since the last load
  logic             clearPrev;  // clear state one cycle ago
  logic             leaving;    // clear state ends this cycle
  logic             loadHit;    // this load pulse updates the latch
  logic             next_dirty; // dirty after this edge
  logic [WIDTH-1:0] next_latch; // latch after this edge

  // ****************************************
  // latch source selection
  // ****************************************
  assign leaving = clearPrev & ~clearNow;
  // only touched channels reload, which avoids needless output glitches
  assign loadHit = loadPulse & syncSelect & dirty & ~clearNow;
  assign next_latch = clearNow ? clearCode
                    : (leaving | loadHit) ? dataReg
                    : latchCode;
  assign next_dirty = dataWrite | (dirty & ~(loadHit | leaving));

  // both buffer stages; host writes only reach dataReg
  always_ff @(posedge clk) begin
    if (reset) begin
      dataReg   <= WIDTH'(`RESET_CODE);
      latchCode <= WIDTH'(`RESET_CODE);
      dirty     <= 1'b0;
      clearPrev <= 1'b0;
    end else begin
      if (dataWrite) begin
        dataReg <= dataIn;
      end
      latchCode <= next_latch;
      dirty     <= next_dirty;
      clearPrev <= clearNow;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_load_copies: assert property (loadPulse && syncSelect && dirty && !clearNow
    |=> latchCode == $past(dataReg))
    else $error("load pulse did not copy data into latch");
  a_clear_code: assert property (clearNow
    |=> latchCode == $past(clearCode))
    else $error("cleared channel latch not at clear code");
  a_clear_exit: assert property ($fell(clearNow)
    |=> latchCode == $past(dataReg, 1) || $past(dataWrite))
    else $error("latch not restored when clear ended");
  a_write_only_data: assert property (dataWrite && !clearNow && !clearPrev
    ##1 !loadPulse && !clearNow |=> $stable(latchCode))
    else $error("data write changed the latch");
  a_untouched_kept: assert property (!dirty && !dataWrite && !clearNow && !clearPrev
    |=> $stable(latchCode))
    else $error("untouched channel reloaded");
endmodule

// [rtl/dac_load_clear_alarm_ctrl.sv]
// top of the dac load, clear and alarm control block with its wishbone slave
// assumes classic single-cycle wishbone, synchronous clear pins and alarm levels
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "dac_ctrl_consts.svh"

// Behaviour
// - reset zeroes data registers, latches and output
// - output buffers start powered down, undriven
// - each channel holds data register then latch
// - reading data address returns latch contents
// - trigger write loads selected channels together
// - data write leaves latch untouched until load
// - load reloads only channels written since
// - entering clear loads clear code into latch
// - leaving clear reloads latch from data register
// - low clear pin clears its selected channels
// - software clear register clears selected channels
// - selected alarm sources clear enabled channels
// - overheat sets its alarm, routable to clear
// - overheat protection off when sensor powered down
// - global alarm is OR of alarm bits
// - latched bits hold until condition gone and read
// - unlatched bits fall when condition ends
// - alarm pin low while an enabled alarm bit set
// - only enabled events drive the alarm pin
module dac_load_clear_alarm_ctrl #(
  parameter int CHANNELS = 12,                     // dac channels
  parameter int WIDTH    = 12,                     // dac code width
  parameter int ALARMS   = 8                       // alarm events, bit 2 is overheat
) (
  input  wire logic                      clk,             // 100 MHz device clock
  input  wire logic                      reset,           // synchronous, active high
  input  wire logic                      wb_cyc_i,        // bus cycle
  input  wire logic                      wb_stb_i,        // bus strobe
  input  wire logic                      wb_we_i,         // 1 = write
  input  wire logic [7:0]                wb_adr_i,        // byte address
  input  wire logic [3:0]                wb_sel_i,        // byte lanes
  input  wire logic [31:0]               wb_dat_i,        // write data
  output logic      [31:0]               wb_dat_o,        // read data
  output logic                           wb_ack_o,        // acknowledge
  input  wire logic                      hwClearPinZeroN, // clear pin zero, low active
  input  wire logic                      hwClearPinOneN,  // clear pin one, low active
  input  wire logic [ALARMS-1:0]         monitorAlarm,    // out-of-range conditions
  input  wire logic                      dieOverTemp,     // die above the limit
  input  wire logic                      localSensorOff,  // local sensor powered down
  output logic      [CHANNELS*WIDTH-1:0] dacCode,         // latched codes, channel 0 low
  output logic      [CHANNELS-1:0]       bufferEnable,    // output buffer powered
  output logic                           alarmPinOut,     // alarm pin level, always 0
  output logic                           alarmPinOe       // alarm pin pulled low
);

  // ****************************************
  // parameter checks
  // ****************************************
  // the auto-clear enables sit in bits 14:3, so at most twelve channels fit
  if (CHANNELS < 1 || CHANNELS > 12) begin : g_bad_channels
    $error("CHANNELS must be 1 to 12");
  end
  // event 2 is the overheat event and enables use bits 15:8
  if (ALARMS < 3 || ALARMS > 8) begin : g_bad_alarms
    $error("ALARMS must be 3 to 8");
  end
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("WIDTH must be 1 to 16");
  end

  // ****************************************
  // helpers
  // ****************************************
  // merges a write into an old word by byte lane
  function automatic dac_ctrl_pkg::word_type merge(
    input dac_ctrl_pkg::word_type oldWord,
    input dac_ctrl_pkg::word_type newWord,
    input dac_ctrl_pkg::sel_type  lanes);
    dac_ctrl_pkg::word_type result;
    result = oldWord;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        result[8*b +: 8] = newWord[8*b +: 8];
      end
    end
    return result;
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  logic [CHANNELS-1:0] syncSelect;           // channels taking part in loads
  logic [CHANNELS-1:0] pinZeroSelect;        // channels cleared by pin zero
  logic [CHANNELS-1:0] pinOneSelect;         // channels cleared by pin one
  logic [CHANNELS-1:0] softwareClear;        // channels cleared by software
  logic [ALARMS-1:0]   autoSource;           // events that trigger auto-clear
  logic [CHANNELS-1:0] autoEnable;           // channels auto-cleared
  logic                latchDisable;         // 1: alarm bits not latched
  logic [ALARMS-1:0]   eventEnable;          // events allowed onto the pin
  logic                loadPulse;            // one-cycle internal load
  logic [WIDTH-1:0]    clearCode [CHANNELS]; // per-channel clear codes
  logic [WIDTH-1:0]    dataReg   [CHANNELS]; // pending data registers
  logic [WIDTH-1:0]    latchCode [CHANNELS]; // output latches
  logic [ALARMS-1:0]   status;               // alarm status bits

  // ****************************************
  // bus decode
  // ****************************************
  logic                   request;      // new access not yet acknowledged
  logic                   writeReq;     // write access taken this cycle
  logic                   readReq;      // read access taken this cycle
  logic [3:0]             chIndex;      // channel of a window access
  logic                   chValid;      // channel index in range
  logic                   inData;       // data window hit
  logic                   inClrCode;    // clear code window hit
  dac_ctrl_pkg::addr_type regOfs;       // address with lane bits dropped
  dac_ctrl_pkg::word_type oldWord;      // stored contents of the target
  dac_ctrl_pkg::word_type readWord;     // value returned on a read
  dac_ctrl_pkg::word_type newWord;      // target after a write
  logic                   globalAlarm;  // OR of the status bits
  logic                   statusRead;   // status register read pulse
  logic                   triggerWrite; // load trigger written with 1

  // a new access is taken only while ack is low, so ack lasts one cycle
  assign request   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign writeReq  = request & wb_we_i;
  assign readReq   = request & ~wb_we_i;
  assign regOfs    = {wb_adr_i[7:2], 2'b00};
  assign chIndex   = wb_adr_i[5:2];
  assign chValid   = 32'(chIndex) < CHANNELS;
  assign inData    = wb_adr_i[7:6] == `WIN_DATA && chValid;
  assign inClrCode = wb_adr_i[7:6] == `WIN_CLR_CODE && chValid;

  // ****************************************
  // register read mux
  // ****************************************
  // stored value of the addressed register, used to merge byte lanes
  always_comb begin
    oldWord = '0;
    if (inData) begin
      oldWord = 32'(dataReg[chIndex]);
    end else if (inClrCode) begin
      oldWord = 32'(clearCode[chIndex]);
    end else begin
      unique case (regOfs)
        `OFS_SYNC_SEL:   oldWord = 32'(syncSelect);
        `OFS_PIN0_SEL:   oldWord = 32'(pinZeroSelect);
        `OFS_PIN1_SEL:   oldWord = 32'(pinOneSelect);
        `OFS_SW_CLEAR:   oldWord = 32'(softwareClear);
        `OFS_AUTO_SRC:   oldWord = 32'(autoSource);
        `OFS_AUTO_EN:    oldWord = 32'(autoEnable) << `LSB_AUTO_EN;
        `OFS_ALARM_CTRL: oldWord = (32'(eventEnable) << `LSB_EVENT_EN)
                                   | 32'(latchDisable);
        `OFS_POWER:      oldWord = 32'(bufferEnable);
        default:         oldWord = '0;  // config, status, unmapped
      endcase
    end
  end

  // a data read shows the latch, not the pending word
  assign readWord = inData ? 32'(latchCode[chIndex])
                  : regOfs == `OFS_STATUS && !inClrCode ? 32'(status)
                  : regOfs == `OFS_CONFIG ? 32'(globalAlarm) << `BIT_GLOBAL_ALARM
                  : oldWord;
  assign newWord      = merge(oldWord, wb_dat_i, wb_sel_i);
  assign statusRead   = readReq && regOfs == `OFS_STATUS;
  assign triggerWrite = writeReq && regOfs == `OFS_CONFIG && wb_sel_i[0]
                        && wb_dat_i[`BIT_LOAD_TRIGGER];

  // bus answer: ack one cycle after the request, read data with it
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= request;
      wb_dat_o <= readReq ? readWord : '0;
    end
  end

  // ****************************************
  // control register writes
  // ****************************************
  // everything resets to zero, so outputs start powered down
  always_ff @(posedge clk) begin
    if (reset) begin
      syncSelect    <= '0;
      pinZeroSelect <= '0;
      pinOneSelect  <= '0;
      softwareClear <= '0;
      autoSource    <= '0;
      autoEnable    <= '0;
      latchDisable  <= 1'b0;
      eventEnable   <= '0;
      bufferEnable  <= '0;
    end else if (writeReq && !inData && !inClrCode) begin
      unique case (regOfs)
        `OFS_SYNC_SEL:   syncSelect    <= newWord[CHANNELS-1:0];
        `OFS_PIN0_SEL:   pinZeroSelect <= newWord[CHANNELS-1:0];
        `OFS_PIN1_SEL:   pinOneSelect  <= newWord[CHANNELS-1:0];
        `OFS_SW_CLEAR:   softwareClear <= newWord[CHANNELS-1:0];
        `OFS_AUTO_SRC:   autoSource    <= newWord[ALARMS-1:0];
        `OFS_AUTO_EN:    autoEnable    <= newWord[`LSB_AUTO_EN +: CHANNELS];
        `OFS_ALARM_CTRL: begin
          latchDisable <= newWord[`BIT_LATCH_DIS];
          eventEnable  <= newWord[`LSB_EVENT_EN +: ALARMS];
        end
        `OFS_POWER:      bufferEnable  <= newWord[CHANNELS-1:0];
        default:         ;  // read-only or unmapped: write ignored
      endcase
    end
  end

  // clear codes; they only matter while a channel is cleared
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int n = 0; n < CHANNELS; n++) begin
        clearCode[n] <= WIDTH'(`RESET_CODE);
      end
    end else if (writeReq && inClrCode) begin
      clearCode[chIndex] <= newWord[WIDTH-1:0];
    end
  end

  // the trigger bit holds no state: one write of 1 gives one pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      loadPulse <= 1'b0;
    end else begin
      loadPulse <= triggerWrite;
    end
  end

  // ****************************************
  // alarms
  // ****************************************
  logic [ALARMS-1:0]   events;       // live conditions with overheat folded in
  logic                overheat;     // protected overheat condition
  logic                autoHit;      // a selected source is set
  logic                pinAlarm;     // an enabled event is set
  logic [CHANNELS-1:0] clearNow;     // per-channel clear state

  // overheat is ignored while the local sensor cannot see the die
  assign overheat = dieOverTemp & ~localSensorOff;
  always_comb begin
    events = monitorAlarm;
    events[`BIT_OVERHEAT_SRC] = overheat;
  end

  alarm_status #(
    .ALARMS       (ALARMS)
  ) u_alarm_status (
    .clk          (clk),
    .reset        (reset),
    .condition    (events),
    .latchDisable (latchDisable),
    .readClear    (statusRead),
    .status       (status)
  );

  assign globalAlarm = |status;
  assign pinAlarm    = |(status & eventEnable);

  // open-drain alarm pin: drive low, otherwise release
  always_ff @(posedge clk) begin
    if (reset) begin
      alarmPinOe  <= 1'b0;
      alarmPinOut <= 1'b0;
    end else begin
      alarmPinOe  <= pinAlarm;
      alarmPinOut <= 1'b0;
    end
  end

  // ****************************************
  // clear sources
  // ****************************************
  // any one source is enough; a channel stays cleared while any holds it
  assign autoHit  = |(status & autoSource);
  assign clearNow = (hwClearPinZeroN ? '0 : pinZeroSelect)
                  | (hwClearPinOneN  ? '0 : pinOneSelect)
                  | softwareClear
                  | (autoHit ? autoEnable : '0);

  // ****************************************
  // channels
  // ****************************************
  for (genvar n = 0; n < CHANNELS; n++) begin : g_channel
    dac_channel #(
      .WIDTH      (WIDTH)
    ) u_channel (
      .clk        (clk),
      .reset      (reset),
      .dataWrite  (writeReq && inData && 32'(chIndex) == n),
      .dataIn     (newWord[WIDTH-1:0]),
      .loadPulse  (loadPulse),
      .syncSelect (syncSelect[n]),
      .clearNow   (clearNow[n]),
      .clearCode  (clearCode[n]),
      .dataReg    (dataReg[n]),
      .latchCode  (latchCode[n])
    );
    assign dacCode[n*WIDTH +: WIDTH] = latchCode[n];
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_trigger;
    triggerWrite;
  endsequence
  sequence s_one_pulse;
    loadPulse ##1 !loadPulse;
  endsequence

  a_trigger_pulse: assert property (s_trigger |=> s_one_pulse)
    else $error("trigger write did not give one load pulse");
  a_read_latch: assert property (readReq && inData
    |=> wb_dat_o == 32'($past(latchCode[chIndex])))
    else $error("data read did not return the latch");
  a_alarm_pin: assert property (##1 alarmPinOe == $past(|(status & eventEnable)))
    else $error("alarm pin does not track enabled alarms");
  a_pin_clear: assert property (!hwClearPinZeroN && pinZeroSelect[0]
    |=> dacCode[WIDTH-1:0] == $past(clearCode[0]))
    else $error("pin clear did not force the clear code");
  a_overheat_off: assert property (localSensorOff && !monitorAlarm[`BIT_OVERHEAT_SRC]
    && latchDisable |=> !status[`BIT_OVERHEAT_SRC])
    else $error("overheat alarm while local sensor is off");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // channel 0 stands for every channel in the clear source checks
  a_pin_one_clear: assert property (!hwClearPinOneN && pinOneSelect[0]
    |=> dacCode[WIDTH-1:0] == $past(clearCode[0]))
    else $error("pin one clear did not force the clear code");
  a_soft_clear: assert property (softwareClear[0]
    |=> dacCode[WIDTH-1:0] == $past(clearCode[0]))
    else $error("software clear did not force the clear code");
  a_config_read: assert property (readReq && regOfs == `OFS_CONFIG
    |=> wb_dat_o[`BIT_GLOBAL_ALARM] == $past(globalAlarm) && !wb_dat_o[`BIT_LOAD_TRIGGER])
    else $error("config read shows wrong alarm or trigger bit");
endmodule

// [test/host_bus_model.sv]
// host side: classic wishbone master making single reads and writes
// assumes the slave answers within 20 cycles, otherwise hung is raised
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        clk,  // device clock
  output logic             cyc,  // bus cycle
  output logic             stb,  // strobe
  output logic             we,   // 1 = write
  output logic [7:0]       adr,  // byte address
  output logic [3:0]       sel,  // byte lanes
  output logic [31:0]      datW, // write data
  input  wire logic [31:0] datR, // read data
  input  wire logic        ack   // acknowledge
);
  bit hung = 0; // a missing ack ends the run
  initial {cyc, stb, we, adr, sel, datW} = '0;
  // ********************
  // one classic cycle, held until ack is sampled; the bench sets select bits
  // before any load it expects to take effect
  // ********************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, datW} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    hung = hung | (ack !== 1'b1);
    q = datR;
    {cyc, stb, we} <= 3'b000; // released only after the ack edge
  endtask
endmodule

// [test/tb.sv]
// bench for the dac load, clear and alarm block
// assumes the register map of the consts header and a 100 MHz clock
`timescale 1ns/1ps
`include "dac_ctrl_consts.svh"
module tb;
  logic clk = 0, reset = 1, pin0N = 1, pin1N = 1, overTemp = 0, sensorOff = 0;
  logic [7:0] alarmIn = '0;
  logic cyc, stb, we, ack, oe, pinOut;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datW, datR, q;
  logic [143:0] code;
  logic [11:0] bufEn;
  int errors = 0, check_count = 0;
  always #5 clk = ~clk;
  host_bus_model host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .datW(datW), .datR(datR), .ack(ack));
  dac_load_clear_alarm_ctrl dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .hwClearPinZeroN(pin0N), .hwClearPinOneN(pin1N), .monitorAlarm(alarmIn),
    .dieOverTemp(overTemp), .localSensorOff(sensorOff), .dacCode(code),
    .bufferEnable(bufEn), .alarmPinOut(pinOut), .alarmPinOe(oe));
  // ********************
  // helpers
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [31:0] ch(input int n);
    return {20'h0, code[n*12 +: 12]};
  endfunction
  task automatic wrap_up;
    errors += int'(host.hung);
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) if (host.hung) wrap_up; // a hung bus cycle stops the run
  // ********************
  // scenarios
  // ********************
  task automatic t_load; // only ch0 is both selected and written
    wr(`OFS_SYNC_SEL, 32'h5);
    wr(8'h40, 32'h123);
    wr(8'h44, 32'h456);
    chk(ch(0), 32'h0);
    rd(8'h40);
    chk(q, 32'h0);
    wr(`OFS_CONFIG, 32'h1);
    cyc_wait(3);
    chk(ch(0), 32'h123);
    chk(ch(1), 32'h0);
    chk(ch(2), 32'h0);
    rd(`OFS_CONFIG);
    chk(q & 32'h1, 32'h0);
  endtask
  task automatic t_clear; // pin then software clear of ch0
    wr(8'h80, 32'habc);
    wr(`OFS_PIN0_SEL, 32'h1);
    pin0N <= 1'b0;
    cyc_wait(3);
    chk(ch(0), 32'habc);
    pin0N <= 1'b1;
    cyc_wait(3);
    chk(ch(0), 32'h123);
    wr(`OFS_PIN1_SEL, 32'h1);
    pin1N <= 1'b0;
    cyc_wait(3);
    chk(ch(0), 32'habc);
    pin1N <= 1'b1;
    cyc_wait(3);
    chk(ch(0), 32'h123);
    wr(`OFS_SW_CLEAR, 32'h1);
    cyc_wait(2);
    chk(ch(0), 32'habc);
    wr(`OFS_SW_CLEAR, 32'h0);
    cyc_wait(2);
    chk(ch(0), 32'h123);
  endtask
  task automatic t_alarm; // event 0 enabled, event 1 masked
    wr(`OFS_ALARM_CTRL, 32'h100);
    alarmIn <= 8'h01;
    cyc_wait(4);
    chk({31'h0, oe}, 32'h1);
    chk({31'h0, pinOut}, 32'h0);
    rd(`OFS_CONFIG);
    chk(q & 32'h2, 32'h2);
    alarmIn <= 8'h02;
    cyc_wait(4);
    chk({31'h0, oe}, 32'h1);
    rd(`OFS_STATUS);
    chk(q & 32'h3, 32'h3);
    cyc_wait(3);
    chk({31'h0, oe}, 32'h0);
    wr(`OFS_ALARM_CTRL, 32'h101);
    alarmIn <= 8'h00;
    cyc_wait(4);
    rd(`OFS_STATUS);
    chk(q & 32'hff, 32'h0);
  endtask
  task automatic t_heat; // overheat routed to ch0 clear
    wr(`OFS_AUTO_SRC, 32'h4);
    wr(`OFS_AUTO_EN, 32'h8);
    sensorOff <= 1'b1;
    overTemp <= 1'b1;
    cyc_wait(4);
    chk(ch(0), 32'h123);
    sensorOff <= 1'b0;
    cyc_wait(4);
    chk(ch(0), 32'habc);
    rd(`OFS_STATUS);
    chk(q & 32'h4, 32'h4);
  endtask
  task automatic t_power; // buffers come up only by register write
    wr(`OFS_POWER, 32'hfff);
    cyc_wait(1);
    chk({20'h0, bufEn}, 32'hfff);
    rd(`OFS_POWER);
    chk(q, 32'hfff);
  endtask
  initial begin
    cyc_wait(3);
    reset <= 1'b0;
    cyc_wait(1);
    chk({31'h0, code === 144'h0}, 32'h1);
    chk({20'h0, bufEn}, 32'h0);
    t_load;
    t_clear;
    t_alarm;
    t_heat;
    t_power;
    wrap_up;
  end
endmodule
